//--- rtl/rie_exc_unit.sv
// Reset and interrupt exception sequencer with a Wishbone register port.
`timescale 1ns/1ps
`include "rie_defines.svh"

module rie_exc_unit
  import rie_pkg::*;
#(
  parameter int EXT_N = 5,
  parameter int WAKE_N = 8,
  parameter int INT_N = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chip_clear_pin_n_i,
  input wire logic [EXT_N-1:0] ext_edge_req_i,
  input wire logic [WAKE_N-1:0] wake_pin_req_i,
  input wire logic [INT_N-1:0] int_req_i,
  input wire logic insn_done_i,
  input wire logic [7:0] fetch_data_i,
  input wire logic fetch_valid_i,
  output logic cpu_halt_o,
  output logic periph_init_o,
  output logic fetch_req_o,
  output logic [15:0] fetch_addr_o,
  output logic branch_o,
  output logic [15:0] branch_addr_o,
  output logic [4:0] vec_num_o,
  output logic global_mask_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int PIN_N = EXT_N + WAKE_N;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Lowest set vector number wins; a result of zero means nothing is pending.
  function automatic rie_vec_t rie_pick(input logic [20:0] pend);
    rie_vec_t v;
    v = 5'h00;
    for (int i = 20; i >= 4; i--) begin
      if (pend[i]) begin
        v = rie_vec_t'(i);
      end
    end
    return v;
  endfunction

  function automatic logic [15:0] rie_slot(input rie_vec_t v,
                                           input logic odd);
    return {10'h000, v, odd};
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  rie_state_e state;
  rie_state_e next_state;
  logic in_reset;
  logic mask;
  logic first_insn;
  logic [PIN_N-1:0] pin_prev;
  logic [PIN_N-1:0] pin_flag;
  logic [PIN_N-1:0] edge_sel;
  logic [PIN_N-1:0] pin_now;
  logic [PIN_N-1:0] pin_edge;
  logic [20:0] pend;
  rie_vec_t win_vec;
  rie_vec_t cur_vec;
  logic [7:0] hi_byte;
  logic take_irq;
  logic wb_req;
  logic wb_wr;
  logic [PIN_N-1:0] flag_clr;
  logic [31:0] rd_data;

  // Chip clear low resets sequencer, flags and mask; only rst_i resets the Wishbone slave.
  assign in_reset = rst_i | ~chip_clear_pin_n_i;
  assign pin_now = {wake_pin_req_i, ext_edge_req_i};

  // --------------------------------------------------------------------
  // Edge detection and request flags
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      // Zero picks the falling edge, one the rising edge.
      pin_edge[i] = edge_sel[i] ? (pin_now[i] & ~pin_prev[i])
                                : (~pin_now[i] & pin_prev[i]);
    end
  end

  always_ff @(posedge clk_i) begin
    pin_prev <= pin_now;
  end

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  // Writing zero to a flag bit clears it, one leaves it alone.
  always_comb begin
    flag_clr = '0;
    if (wb_wr && wb_adr_i == `RIE_OFS_FLAG) begin
      for (int i = 0; i < PIN_N; i++) begin
        if (wb_sel_i[i/8]) begin
          flag_clr[i] = ~wb_dat_i[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      pin_flag <= '0;
    end else begin
      // Flags set regardless of the mask; a new edge beats a clear.
      pin_flag <= (pin_flag & ~flag_clr) | pin_edge;
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      edge_sel <= `RIE_EDGE_RST;
    end else if (wb_wr && wb_adr_i == `RIE_OFS_EDGE) begin
      for (int i = 0; i < PIN_N; i++) begin
        if (wb_sel_i[i/8]) begin
          edge_sel[i] <= wb_dat_i[i];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Priority map
  // --------------------------------------------------------------------
  always_comb begin
    pend = '0;
    // External pins take vectors 4 to 8, wake pins share 9.
    pend[8:4] = pin_flag[4:0];
    pend[`RIE_VEC_WAKE] = |pin_flag[PIN_N-1:EXT_N];
    // Timer, serial, conversion-end and sleep vectors.
    pend[`RIE_VEC_SER1] = int_req_i[`RIE_IRQ_SER1];
    pend[11] = int_req_i[`RIE_IRQ_ITMR];
    pend[12] = int_req_i[`RIE_IRQ_ACNT];
    pend[13] = int_req_i[`RIE_IRQ_UDTM];
    pend[14] = |int_req_i[`RIE_IRQ_CTL_LO +: 2];
    pend[15] = |int_req_i[`RIE_IRQ_CTH_LO +: 2];
    pend[16] = |int_req_i[`RIE_IRQ_CAP_LO +: 2];
    pend[17] = |int_req_i[`RIE_IRQ_AS1_LO +: 6];
    pend[18] = |int_req_i[`RIE_IRQ_AS2_LO +: 6];
    pend[19] = int_req_i[`RIE_IRQ_ADC];
    pend[`RIE_VEC_LOWEST] = int_req_i[`RIE_IRQ_SLEEP];
  end

  assign win_vec = rie_pick(pend);

  // Masked requests are not dropped, they simply wait here.
  // Only at an instruction boundary in normal running.
  assign take_irq = (state == RIE_ST_RUN) & insn_done_i & ~mask &
                    ~first_insn & (win_vec != `RIE_VEC_RESET);

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      // Reset fetch begins the first cycle after release.
      RIE_ST_RESET: next_state = RIE_ST_FETCH_HI;
      RIE_ST_RUN: begin
        if (take_irq) begin
          next_state = RIE_ST_FETCH_HI;
        end
      end
      RIE_ST_FETCH_HI: begin
        if (fetch_valid_i) begin
          next_state = RIE_ST_FETCH_LO;
        end
      end
      RIE_ST_FETCH_LO: begin
        if (fetch_valid_i) begin
          next_state = RIE_ST_BRANCH;
        end
      end
      RIE_ST_BRANCH: next_state = RIE_ST_RUN;
      default: next_state = RIE_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      state <= RIE_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      cur_vec <= `RIE_VEC_RESET;
    end else if (take_irq) begin
      cur_vec <= win_vec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      hi_byte <= 8'h00;
    end else if (state == RIE_ST_FETCH_HI && fetch_valid_i) begin
      hi_byte <= fetch_data_i;
    end
  end

  // Vector fetch port: held until the memory answers.
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      fetch_req_o <= 1'b0;
      fetch_addr_o <= 16'h0000;
    end else begin
      case (next_state)
        RIE_ST_FETCH_HI: begin
          fetch_req_o <= 1'b1;
          fetch_addr_o <= rie_slot(
              (state == RIE_ST_RESET) ? `RIE_VEC_RESET : (take_irq ?
              win_vec : cur_vec), 1'b0);
        end
        RIE_ST_FETCH_LO: begin
          fetch_req_o <= 1'b1;
          fetch_addr_o <= rie_slot(cur_vec, 1'b1);
        end
        default: begin
          fetch_req_o <= 1'b0;
          fetch_addr_o <= fetch_addr_o;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      branch_o <= 1'b0;
      branch_addr_o <= 16'h0000;
      vec_num_o <= `RIE_VEC_RESET;
    end else begin
      branch_o <= (state == RIE_ST_FETCH_LO) & fetch_valid_i;
      if (state == RIE_ST_FETCH_LO && fetch_valid_i) begin
        branch_addr_o <= {hi_byte, fetch_data_i};
        vec_num_o <= cur_vec;
      end
    end
  end

  // Halt and peripheral initialization are registered copies of the reset condition, one cycle later.
  always_ff @(posedge clk_i) begin
    cpu_halt_o <= in_reset;
    periph_init_o <= in_reset;
  end

  // --------------------------------------------------------------------
  // Global mask and first-instruction guard
  // --------------------------------------------------------------------
  // Software may clear the mask before the first instruction retires,
  // so a separate guard keeps the stack-pointer setup safe.
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      first_insn <= 1'b1;
    end else if (state == RIE_ST_RUN && insn_done_i) begin
      first_insn <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      mask <= `RIE_MASK_RST;
    end else if (take_irq) begin
      mask <= 1'b1;
    end else if (wb_wr && wb_adr_i == `RIE_OFS_CTRL && wb_sel_i[0]) begin
      mask <= wb_dat_i[`RIE_CTRL_MASK_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      global_mask_o <= `RIE_MASK_RST;
    end else begin
      global_mask_o <= mask;
    end
  end

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `RIE_OFS_CTRL: rd_data[`RIE_CTRL_MASK_BIT] = mask;
      `RIE_OFS_EDGE: rd_data[PIN_N-1:0] = edge_sel;
      `RIE_OFS_FLAG: rd_data[PIN_N-1:0] = pin_flag;
      `RIE_OFS_ILVL: rd_data[INT_N-1:0] = int_req_i;
      `RIE_OFS_STAT: rd_data = {19'h00000, first_insn, cur_vec, 2'b00,
                                state};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Every access, mapped or not, is answered one cycle later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // rie_exc_unit

//--- include/rie_defines.svh
// Constants for the reset and interrupt exception unit.
// Notes on behaviour
// - Reset outranks everything; its vector fetch starts as soon as reset ends.
// - Interrupts are taken only at an instruction boundary, never mid-exception.
// - Chip clear pin low halts all processing and holds the reset state.
// - Reset initializes CPU and peripheral state and sets the global mask to one.
// - After reset the program counter loads from vector bytes 0x0000 and 0x0001.
// - Interrupts stay masked until the first instruction after reset has run.
// - Thirteen external and twenty-four internal request inputs are accepted.
// - The highest-priority pending request wins; vector number order, 20 lowest.
// - With the global mask set, flags still set but nothing is accepted.
// - Each external and wake pin picks rising or falling edge detection.
// - External pins use vectors 4 to 8; all wake pins share vector 9.
// - Timers use vectors 11, 12, 13, 14 and 15 as assigned.
// - First serial unit uses 10; async serial channels use 17 and 18.
// - Capture timer uses vector 16; conversion end uses vector 19.
// - Edge select zero means falling edge and is the reset value.
`ifndef RIE_DEFINES_SVH
`define RIE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RIE_OFS_CTRL 8'h00
`define RIE_OFS_EDGE 8'h04
`define RIE_OFS_FLAG 8'h08
`define RIE_OFS_ILVL 8'h0c
`define RIE_OFS_STAT 8'h10

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RIE_CTRL_MASK_BIT 0
`define RIE_EDGE_RST 13'h0000
`define RIE_MASK_RST 1'b1

// ----------------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------------
`define RIE_VEC_RESET 5'h00
`define RIE_VEC_EXT0 5'h04
`define RIE_VEC_WAKE 5'h09
`define RIE_VEC_SER1 5'h0a
`define RIE_VEC_LOWEST 5'h14

// Internal request bit positions and their vectors.
`define RIE_IRQ_SER1 0
`define RIE_IRQ_ITMR 1
`define RIE_IRQ_ACNT 2
`define RIE_IRQ_UDTM 3
`define RIE_IRQ_CTL_LO 4
`define RIE_IRQ_CTH_LO 6
`define RIE_IRQ_CAP_LO 8
`define RIE_IRQ_AS1_LO 10
`define RIE_IRQ_AS2_LO 16
`define RIE_IRQ_ADC 22
`define RIE_IRQ_SLEEP 23

`endif

//--- include/rie_pkg.sv
// Types shared by the reset and interrupt exception unit.
package rie_pkg;
  typedef enum logic [4:0] {
    RIE_ST_RESET = 5'b00001,
    RIE_ST_RUN = 5'b00010,
    RIE_ST_FETCH_HI = 5'b00100,
    RIE_ST_FETCH_LO = 5'b01000,
    RIE_ST_BRANCH = 5'b10000
  } rie_state_e;

  typedef logic [4:0] rie_vec_t;
endpackage

//--- bench/rie_exc_sva.sv
// Concurrent checks on the exception unit's ports.
`timescale 1ns/1ps
module rie_exc_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chip_clear_pin_n_i,
  input wire logic insn_done_i,
  input wire logic [7:0] fetch_data_i,
  input wire logic fetch_valid_i,
  input wire logic cpu_halt_o,
  input wire logic periph_init_o,
  input wire logic fetch_req_o,
  input wire logic [15:0] fetch_addr_o,
  input wire logic branch_o,
  input wire logic [15:0] branch_addr_o,
  input wire logic [4:0] vec_num_o,
  input wire logic global_mask_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_HALT: assert property (
    !chip_clear_pin_n_i [*2] |=> cpu_halt_o && periph_init_o)
    else $error("halt or init missing while the pin is low");
  AST_MASK_SET: assert property (
    !chip_clear_pin_n_i |=> global_mask_o && !branch_o)
    else $error("mask clear or branch during reset");
  AST_RST_FETCH: assert property (
    $rose(chip_clear_pin_n_i) |=> fetch_req_o && fetch_addr_o == 16'h0000)
    else $error("reset vector fetch did not start");
  AST_BOUNDARY: assert property (
    $rose(fetch_req_o) |-> $past(insn_done_i) ||
      !$past(chip_clear_pin_n_i, 2) || $past(rst_i, 2))
    else $error("fetch started off an instruction boundary");
  AST_MASKED: assert property (
    $rose(fetch_req_o) && $past(chip_clear_pin_n_i, 2) |->
      !$past(global_mask_o) ##1 global_mask_o)
    else $error("interrupt taken while masked or mask not set");
  AST_HOLD: assert property (
    fetch_req_o && !fetch_valid_i && chip_clear_pin_n_i |=>
      fetch_req_o && $stable(fetch_addr_o))
    else $error("fetch request dropped or moved before answer");
  AST_ODD: assert property (
    fetch_req_o && fetch_valid_i && !fetch_addr_o[0] && chip_clear_pin_n_i
      |=> fetch_addr_o == $past(fetch_addr_o) + 16'h0001)
    else $error("low byte fetch not at the odd address");
  AST_BRANCH: assert property (
    fetch_req_o && fetch_valid_i && fetch_addr_o[0] && chip_clear_pin_n_i
      |=> branch_o && branch_addr_o[7:0] == $past(fetch_data_i) &&
      16'({vec_num_o, 1'b1}) == $past(fetch_addr_o))
    else $error("branch missing or wrong after low byte");
endmodule // rie_exc_sva

//--- bench/rie_mem_model.sv
// Vector memory that answers the unit's fetches after a varying wait.
`timescale 1ns/1ps
module rie_mem_model (
  input wire logic clk_i,
  input wire logic fetch_req_i,
  input wire logic [15:0] fetch_addr_i,
  output logic [7:0] fetch_data_o,
  output logic fetch_valid_o
);
  logic [2:0] wait_cnt = 3'h0;
  logic [2:0] lat = 3'h0;
  logic [7:0] noise = 8'h00;
  // Data outside a valid pulse changes every cycle so a stale read shows.
  always_ff @(posedge clk_i) begin
    noise <= noise + 8'h3b;
    fetch_valid_o <= 1'b0;
    fetch_data_o <= noise;
    if (fetch_req_i && fetch_valid_o !== 1'b1) begin
      wait_cnt <= wait_cnt + 3'h1;
      if (wait_cnt == lat) begin
        wait_cnt <= 3'h0;
        lat <= lat + 3'h1;
        fetch_valid_o <= 1'b1;
        fetch_data_o <= fetch_addr_i[0] ? ~fetch_addr_i[7:0] :
          {3'b100, fetch_addr_i[5:1]};
      end
    end
  end
endmodule // rie_mem_model

//--- bench/reset_and_interrupt_exception_unit_test.sv
// Self-checking bench for the exception unit.
`timescale 1ns/1ps
module reset_and_interrupt_exception_unit_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic chip_clear_pin_n_i = 1'b0;
  logic [4:0] ext_edge_req_i = 5'h1f;
  logic [7:0] wake_pin_req_i = 8'h00;
  logic [23:0] int_req_i = 24'h000000;
  logic insn_done_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [7:0] fetch_data_i;
  logic fetch_valid_i, cpu_halt_o, periph_init_o, fetch_req_o, branch_o;
  logic global_mask_o, wb_ack_o;
  logic [15:0] fetch_addr_o, branch_addr_o;
  logic [4:0] vec_num_o;
  logic [4:0] bits [8] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h09,
    5'h0f, 5'h15};
  logic [4:0] vecs [8] = '{5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
    5'h11, 5'h12};
  int failures = 0;
  int samples_checked = 0;
  always #4 clk_i = ~clk_i;
  rie_exc_unit DUT (.clk_i, .rst_i, .chip_clear_pin_n_i, .ext_edge_req_i,
    .wake_pin_req_i, .int_req_i, .insn_done_i, .fetch_data_i, .fetch_valid_i,
    .cpu_halt_o, .periph_init_o, .fetch_req_o, .fetch_addr_o, .branch_o,
    .branch_addr_o, .vec_num_o, .global_mask_o, .wb_cyc_i,
    .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i,
    .wb_dat_o, .wb_ack_o);
  rie_mem_model u_mem (.clk_i, .fetch_req_i(fetch_req_o),
    .fetch_addr_i(fetch_addr_o), .fetch_data_o(fetch_data_i),
    .fetch_valid_o(fetch_valid_i));
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up(input int k);
    if (k >= 60) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 60);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    @(posedge clk_i);
    give_up(k);
  endtask
  task automatic pulse();
    insn_done_i <= 1'b1;
    @(posedge clk_i);
    insn_done_i <= 1'b0;
  endtask
  // Slot contents mirror the memory model: high byte then inverted address.
  task automatic expect_branch(input logic [4:0] v);
    int k;
    k = 0;
    while (branch_o !== 1'b1 && k < 60) begin
      @(posedge clk_i);
      k++;
    end
    give_up(k);
    chk(32'(vec_num_o), 32'(v));
    chk(32'(branch_addr_o), {16'h0, 3'b100, v, ~{2'b00, v, 1'b1}});
    @(posedge clk_i);
  endtask
  task automatic take(input logic [4:0] v);
    wb(1'b1, 8'h00, 32'h0);
    pulse();
    expect_branch(v);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(32'(cpu_halt_o), 32'h1);
    chk(32'(periph_init_o & global_mask_o), 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h0);
    chip_clear_pin_n_i <= 1'b1;
    expect_branch(5'h00);
    chk(32'({cpu_halt_o, periph_init_o}), 32'h0);
    int_req_i <= 24'h800000;
    wb(1'b1, 8'h00, 32'h0);
    // The first boundary after reset must not start a fetch.
    pulse();
    repeat (4) @(posedge clk_i);
    chk(32'(fetch_req_o), 32'h0);
    take(5'h14);
    ext_edge_req_i <= 5'h1b;
    int_req_i <= 24'h400001;
    pulse();
    repeat (10) @(posedge clk_i);
    chk(32'(fetch_req_o), 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'h4);
    take(5'h06);
    wb(1'b1, 8'h08, 32'h1ffb);
    take(5'h0a);
    int_req_i <= 24'h400000;
    take(5'h13);
    for (int i = 0; i < 8; i++) begin
      int_req_i <= 24'h000001 << bits[i];
      take(vecs[i]);
    end
    int_req_i <= 24'h000000;
    wb(1'b1, 8'h04, 32'h20);
    wake_pin_req_i <= 8'h01;
    take(5'h09);
    chip_clear_pin_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(32'(cpu_halt_o), 32'h1);
    chk(32'(fetch_req_o), 32'h0);
    chip_clear_pin_n_i <= 1'b1;
    expect_branch(5'h00);
    print_verdict();
  end
endmodule // reset_and_interrupt_exception_unit_test
bind rie_exc_unit rie_exc_sva u_sva (.clk_i, .rst_i, .chip_clear_pin_n_i,
  .insn_done_i, .fetch_data_i, .fetch_valid_i, .cpu_halt_o, .periph_init_o,
  .fetch_req_o, .fetch_addr_o, .branch_o, .branch_addr_o, .vec_num_o,
  .global_mask_o);
